// file: pdt_pkg.sv
package pdt_pkg;

  // apb address width and data width
  localparam int          PDT_AW             = 12;
  localparam int          PDT_DW             = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PRESCALER      = 8'hD2;
  localparam logic [7:0]  IDX_COUNTER        = 8'hD3;
  localparam logic [7:0]  IDX_CTRL_STATUS    = 8'hD4;
  localparam logic [7:0]  IDX_INT_STATUS     = 8'hD5;
  localparam logic [7:0]  IDX_INT_ENABLE     = 8'hD6;
  localparam logic [7:0]  IDX_INT_CLEAR      = 8'hD7;

  // byte addresses derived from the indices
  localparam logic [11:0] ADDR_PRESCALER     = {2'b00, IDX_PRESCALER, 2'b00};
  localparam logic [11:0] ADDR_COUNTER       = {2'b00, IDX_COUNTER, 2'b00};
  localparam logic [11:0] ADDR_CTRL_STATUS   = {2'b00, IDX_CTRL_STATUS, 2'b00};
  localparam logic [11:0] ADDR_INT_STATUS    = {2'b00, IDX_INT_STATUS, 2'b00};
  localparam logic [11:0] ADDR_INT_ENABLE    = {2'b00, IDX_INT_ENABLE, 2'b00};
  localparam logic [11:0] ADDR_INT_CLEAR     = {2'b00, IDX_INT_CLEAR, 2'b00};

  // field positions
  localparam int          PRESCALER_TOP_POS  = 7;
  localparam int          FLAG_POS           = 7;
  localparam int          INT_UNDERFLOW_POS  = 0;

  // reset values, then the counter wrap and zero values
  localparam logic [6:0]  PRESCALER_RESET    = 7'h7F;
  localparam logic [7:0]  COUNTER_RESET      = 8'hFF;
  localparam logic [7:0]  CTRL_RESET         = 8'h00;
  localparam logic [7:0]  COUNTER_WRAP       = 8'hFF;
  localparam logic [7:0]  COUNTER_ZERO       = 8'h00;

  // control and status layout, bit 7 down to bit 0
  typedef struct packed {
    logic       underflow_flag;
    logic       underflow_irq_enable;
    logic       reserved_bit5_set;
    logic       reserved_bit4_clear;
    logic       prescaler_run;
    logic [2:0] division_select;
  } pdt_ctrl_t;

endpackage

// file: pdt_timer.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module pdt_timer (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pdt_pkg::PDT_AW-1:0] paddr,
  input  wire logic [pdt_pkg::PDT_DW-1:0] pwdata,
  output logic      [pdt_pkg::PDT_DW-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq
);
  import pdt_pkg::*;

  logic [6:0]        prescaler_reg;
  logic [7:0]        counter_reg;
  pdt_ctrl_t         ctrl_reg;
  logic              int_status_reg;
  logic              int_enable_reg;
  logic [PDT_DW-1:0] prdata_reg;
  logic              pslverr_reg;
  logic [PDT_DW-1:0] read_data;
  logic              addr_mapped;
  logic              apb_setup;
  logic              apb_write;
  logic              wr_prescaler;
  logic              wr_counter;
  logic              wr_ctrl;
  logic              wr_int_enable;
  logic              wr_int_clear;
  logic              tick;
  logic              underflow;

  // address compare against one register
  function automatic logic addr_hit(input logic [PDT_AW-1:0] a, input logic [PDT_AW-1:0] r);
    return a == r;
  endfunction

  // tick once every 2**sel clocks, when the low sel bits of the prescaler are zero
  function automatic logic div_tick(input logic [6:0] pre, input logic [2:0] sel);
    logic [7:0] mask;
    mask = (8'h01 << sel) - 8'h01;
    return (pre & mask[6:0]) == 7'h00;
  endfunction

  // apb decode
  assign apb_setup     = psel & ~penable;
  assign apb_write     = psel & penable & pwrite;
  assign wr_prescaler  = apb_write & addr_hit(paddr, ADDR_PRESCALER);
  assign wr_counter    = apb_write & addr_hit(paddr, ADDR_COUNTER);
  assign wr_ctrl       = apb_write & addr_hit(paddr, ADDR_CTRL_STATUS);
  assign wr_int_enable = apb_write & addr_hit(paddr, ADDR_INT_ENABLE);
  assign wr_int_clear  = apb_write & addr_hit(paddr, ADDR_INT_CLEAR);
  assign addr_mapped   = addr_hit(paddr, ADDR_PRESCALER) | addr_hit(paddr, ADDR_COUNTER)
                       | addr_hit(paddr, ADDR_CTRL_STATUS) | addr_hit(paddr, ADDR_INT_STATUS)
                       | addr_hit(paddr, ADDR_INT_ENABLE) | addr_hit(paddr, ADDR_INT_CLEAR);

  // timer tick and underflow event
  assign tick      = ctrl_reg.prescaler_run
                   & div_tick(prescaler_reg, ctrl_reg.division_select);
  assign underflow = tick & (counter_reg == COUNTER_ZERO);

  // prescaler: reloaded with PRESCALER_RESET while stopped, else write or decrement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_reg <= PRESCALER_RESET;
    end else if (!ctrl_reg.prescaler_run) begin
      prescaler_reg <= PRESCALER_RESET;
    end else if (wr_prescaler) begin
      prescaler_reg <= pwdata[6:0];
    end else begin
      prescaler_reg <= prescaler_reg - 7'h01;
    end
  end

  // timer count: write wins, else decrement on tick with wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_reg <= COUNTER_RESET;
    end else if (wr_counter) begin
      counter_reg <= pwdata[7:0];
    end else if (tick) begin
      counter_reg <= counter_reg - 8'h01;
    end
  end

  // control fields and underflow flag, one process so the register has one driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.underflow_irq_enable <= pwdata[6];
        ctrl_reg.reserved_bit5_set    <= pwdata[5];
        ctrl_reg.reserved_bit4_clear  <= pwdata[4];
        ctrl_reg.prescaler_run        <= pwdata[3];
        ctrl_reg.division_select      <= pwdata[2:0];
      end
      if (underflow) begin
        ctrl_reg.underflow_flag <= 1'b1;
      end else if (wr_ctrl && !pwdata[FLAG_POS]) begin
        ctrl_reg.underflow_flag <= 1'b0;
      end
    end
  end

  // sticky interrupt status, write-one-to-clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= 1'b0;
    end else if (underflow) begin
      int_status_reg <= 1'b1;
    end else if (wr_int_clear && pwdata[INT_UNDERFLOW_POS]) begin
      int_status_reg <= 1'b0;
    end
  end

  // interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable_reg <= 1'b0;
    end else if (wr_int_enable) begin
      int_enable_reg <= pwdata[INT_UNDERFLOW_POS];
    end
  end

  // read mux, unused bits read as zero
  always_comb begin
    read_data = '0;
    case (1'b1)
      addr_hit(paddr, ADDR_PRESCALER):   read_data[6:0] = prescaler_reg;
      addr_hit(paddr, ADDR_COUNTER):     read_data[7:0] = counter_reg;
      addr_hit(paddr, ADDR_CTRL_STATUS): read_data[7:0] = ctrl_reg;
      addr_hit(paddr, ADDR_INT_STATUS):  read_data[INT_UNDERFLOW_POS] = int_status_reg;
      addr_hit(paddr, ADDR_INT_ENABLE):  read_data[INT_UNDERFLOW_POS] = int_enable_reg;
      default:                           read_data = '0;
    endcase
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg  <= pwrite ? '0 : read_data;
      pslverr_reg <= ~addr_mapped;
    end
  end

  // outputs
  assign prdata  = prdata_reg;
  assign pready  = 1'b1;                                 // zero wait states
  assign pslverr = pslverr_reg & psel & penable;
  assign irq     = (ctrl_reg.underflow_irq_enable & ctrl_reg.underflow_flag)
                 | (int_status_reg & int_enable_reg);

  // helper: low until the first edge after reset release
  logic seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_prescaler_top_zero: assert property (
    psel && penable && !pwrite && addr_hit(paddr, ADDR_PRESCALER)
    |-> prdata[PDT_DW-1:PRESCALER_TOP_POS] == '0)
    else $error("prescaler read shows nonzero top bits");

  chk_reset_prescaler: assert property (!seen_reg |-> prescaler_reg == 7'h7F)
    else $error("prescaler not 7Fh after reset");

  chk_reset_counter: assert property (!seen_reg |-> counter_reg == 8'hFF)
    else $error("counter not FFh after reset");

  chk_reset_ctrl: assert property (!seen_reg |-> ctrl_reg == 8'h00 && !irq)
    else $error("control not 00h after reset");

  chk_underflow_sets: assert property (
    ctrl_reg.prescaler_run && counter_reg == 8'h00 && !wr_counter
    && div_tick(prescaler_reg, ctrl_reg.division_select)
    |=> counter_reg == 8'hFF && ctrl_reg.underflow_flag)
    else $error("underflow did not wrap and flag");

  chk_flag_sticky: assert property (
    ctrl_reg.underflow_flag && !(wr_ctrl && !pwdata[FLAG_POS]) |=> ctrl_reg.underflow_flag)
    else $error("underflow flag dropped without software clear");

  chk_irq_follows: assert property (
    (ctrl_reg.underflow_irq_enable && ctrl_reg.underflow_flag) |-> irq)
    else $error("interrupt missing with enable and flag set");

  chk_irq_disabled: assert property (
    !ctrl_reg.underflow_irq_enable && !(int_status_reg && int_enable_reg) |-> !irq)
    else $error("interrupt raised while disabled");

  chk_stop_holds: assert property (
    !ctrl_reg.prescaler_run && !wr_counter
    |=> prescaler_reg == 7'h7F && counter_reg == $past(counter_reg))
    else $error("counting while stopped");

  chk_prescaler_dec: assert property (
    ctrl_reg.prescaler_run && !wr_prescaler
    |=> prescaler_reg == 7'($past(prescaler_reg) - 7'h01))
    else $error("prescaler did not decrement");

  chk_div_slowest: assert property (
    ctrl_reg.prescaler_run && ctrl_reg.division_select == 3'h7
    && prescaler_reg != 7'h00 && !wr_counter |=> $stable(counter_reg))
    else $error("timer ticked early at divide by 128");

  chk_div_one: assert property (
    ctrl_reg.prescaler_run && ctrl_reg.division_select == 3'h0 && !wr_counter
    |=> counter_reg == 8'($past(counter_reg) - 8'h01))
    else $error("timer did not count at divide by one");

  chk_counter_write: assert property (
    wr_counter |=> counter_reg == $past(pwdata[7:0]))
    else $error("counter write not taken");

  chk_prescaler_write: assert property (
    ctrl_reg.prescaler_run && wr_prescaler |=> prescaler_reg == $past(pwdata[6:0]))
    else $error("prescaler write not taken while running");

  chk_prescaler_read: assert property (
    psel && penable && !pwrite && addr_hit(paddr, ADDR_PRESCALER)
    |-> prdata[6:0] == $past(prescaler_reg))
    else $error("prescaler read data wrong");

  chk_counter_read: assert property (
    psel && penable && !pwrite && addr_hit(paddr, ADDR_COUNTER)
    |-> prdata == {24'h000000, $past(counter_reg)})
    else $error("counter read data wrong");

  chk_div_two: assert property (
    ctrl_reg.prescaler_run && ctrl_reg.division_select == 3'h1
    && prescaler_reg[0] && !wr_counter |=> $stable(counter_reg))
    else $error("timer ticked on odd prescaler at divide by two");

  chk_ctrl_write: assert property (
    wr_ctrl |=> ctrl_reg.prescaler_run == $past(pwdata[3])
    && ctrl_reg.division_select == $past(pwdata[2:0]))
    else $error("control write not taken");

  chk_flag_clears: assert property (
    wr_ctrl && !pwdata[FLAG_POS] && !underflow |=> !ctrl_reg.underflow_flag)
    else $error("underflow flag not cleared by software");

  chk_flag_rise: assert property (
    $rose(ctrl_reg.underflow_flag) |-> $past(underflow))
    else $error("underflow flag set without a wrap");

  chk_status_set: assert property (underflow |=> int_status_reg)
    else $error("status not set on underflow");

  chk_status_sticky: assert property (
    int_status_reg && !(wr_int_clear && pwdata[INT_UNDERFLOW_POS]) |=> int_status_reg)
    else $error("status dropped without a clear");

  chk_status_clear: assert property (
    wr_int_clear && pwdata[INT_UNDERFLOW_POS] && !underflow |=> !int_status_reg)
    else $error("status not cleared");

  chk_enable_write: assert property (
    wr_int_enable |=> int_enable_reg == $past(pwdata[INT_UNDERFLOW_POS]))
    else $error("interrupt enable write not taken");

  chk_reset_status: assert property (
    !seen_reg |-> !int_status_reg && !int_enable_reg)
    else $error("interrupt registers not clear after reset");

  chk_slverr_unmapped: assert property (
    psel && penable && !addr_mapped |-> pslverr)
    else $error("no error on unmapped address");

  chk_slverr_mapped: assert property (
    psel && penable && addr_mapped |-> !pslverr)
    else $error("error on mapped address");

  chk_unmapped_zero: assert property (
    psel && penable && !pwrite && !addr_mapped |-> prdata == '0)
    else $error("unmapped read not zero");

  cov_underflow_irq: cover property (underflow && ctrl_reg.underflow_irq_enable ##1 irq);
  cov_clear_flag: cover property (ctrl_reg.underflow_flag ##1 !ctrl_reg.underflow_flag);
  cov_slow_tick: cover property (tick && ctrl_reg.division_select == 3'h7);
  cov_write_running: cover property (wr_prescaler && ctrl_reg.prescaler_run);
  cov_div_two_tick: cover property (tick && ctrl_reg.division_select == 3'h1);

endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  import pdt_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [PDT_AW-1:0] paddr;
  logic [PDT_DW-1:0] pwdata;
  logic [PDT_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  int                num_errors;
  int                cmp_count;
  int                cycles;
  logic [31:0]       rd;
  logic [31:0]       rd2;
  logic [31:0]       wv;
  logic              err;

  pdt_timer dut_u (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq)
  );

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; result left in rd and err
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // let register updates and irq settle
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // counter after gap clocks at divide 2**s
  function automatic logic [31:0] exp_count(input logic [31:0] c, input int s, input int gap);
    return (c - (gap >> s)) & 32'hFF;
  endfunction

  // main sequence
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    presetn = 1'b0; num_errors = 0; cmp_count = 0;
    void'($urandom(60));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_PRESCALER, 0);   chk("prescaler reset", 32'h7F, rd);
    apb(0, ADDR_COUNTER, 0);     chk("counter reset", 32'hFF, rd);
    apb(0, ADDR_CTRL_STATUS, 0); chk("ctrl reset", 32'h00, rd);
    chk("irq reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    apb(1, ADDR_PRESCALER, $urandom & 32'h7F);
    apb(0, ADDR_PRESCALER, 0);   chk("prescaler held", 32'h7F, rd);
    wv = $urandom & 32'hFF;
    apb(1, ADDR_COUNTER, wv);
    repeat (20) @(posedge pclk);
    apb(0, ADDR_COUNTER, 0);     chk("counter stopped", wv, rd);
    $display("test stopped done");
    apb(1, ADDR_CTRL_STATUS, 32'h28);
    wv = ($urandom & 32'h7F) | 32'h80;
    apb(1, ADDR_PRESCALER, wv);
    apb(0, ADDR_PRESCALER, 0);   chk("prescaler write", (wv - 1) & 32'h7F, rd);
    rd2 = rd;
    apb(0, ADDR_PRESCALER, 0);   chk("prescaler step", (rd2 - 3) & 32'h7F, rd);
    $display("test prescaler done");
    for (int s = 0; s < 8; s++) begin
      apb(1, ADDR_CTRL_STATUS, 32'h28 | s);
      apb(0, ADDR_COUNTER, 0);
      rd2 = rd;
      repeat (381) @(posedge pclk);
      apb(0, ADDR_COUNTER, 0);   chk("counter ticks", exp_count(rd2, s, 384), rd);
    end
    $display("test division done");
    apb(1, ADDR_CTRL_STATUS, 32'h20);
    apb(1, ADDR_INT_CLEAR, 1);
    apb(0, ADDR_INT_STATUS, 0);  chk("status cleared", 32'h0, rd);
    apb(1, ADDR_COUNTER, 2);
    apb(1, ADDR_CTRL_STATUS, 32'h28);
    repeat (8) @(posedge pclk);
    #1;
    chk("irq disabled", 32'h0, {31'h0, irq});
    apb(1, ADDR_CTRL_STATUS, 32'hA0);
    apb(0, ADDR_CTRL_STATUS, 0); chk("flag set", 32'hA0, rd);
    repeat (60) @(posedge pclk);
    apb(0, ADDR_CTRL_STATUS, 0); chk("flag sticky", 32'hA0, rd);
    apb(1, ADDR_CTRL_STATUS, 32'hE0);
    settle();                    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1, ADDR_CTRL_STATUS, 32'h20);
    settle();                    chk("irq dropped", 32'h0, {31'h0, irq});
    apb(0, ADDR_CTRL_STATUS, 0); chk("flag cleared", 32'h20, rd);
    $display("test underflow done");
    apb(1, ADDR_INT_STATUS, 0);
    apb(0, ADDR_INT_STATUS, 0);  chk("status sticky", 32'h1, rd);
    apb(1, ADDR_INT_ENABLE, 1);
    settle();                    chk("irq enabled", 32'h1, {31'h0, irq});
    apb(1, ADDR_INT_ENABLE, 0);
    settle();                    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1, ADDR_INT_ENABLE, 1);
    apb(1, ADDR_INT_CLEAR, 1);
    settle();                    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(0, ADDR_INT_STATUS, 0);  chk("status clear", 32'h0, rd);
    apb(0, ADDR_INT_CLEAR, 0);   chk("clear reads", 32'h0, rd);
    apb(0, ADDR_INT_ENABLE, 0);  chk("enable reads", 32'h1, rd);
    $display("test interrupt done");
    apb(0, 12'h100, 0);          chk("unmapped read err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1, 12'h100, $urandom);   chk("unmapped write err", 32'h1, {31'h0, err});
    apb(0, ADDR_COUNTER, 0);     chk("mapped err", 32'h0, {31'h0, err});
    chk("pready", 32'h1, {31'h0, pready});
    $display("test unmapped done");
    stop_test();
  end
endmodule
